/* hw/ladder_coil_map.svh */
// constants of the coil and edge instruction logic
// assumes inclusion by bare name from the package and the modules
`ifndef LADDER_COIL_MAP_SVH
`define LADDER_COIL_MAP_SVH
// boolean stack depth and index width
`define STACK_DEPTH 4'h8
`define DEPTH_W 4
// edge history slots and slot index width
`define EDGE_SLOTS 32
`define SLOT_W 5
// or-combined coil accumulator slots
`define OR_SLOTS 16
// largest bit index of a word
`define BIT_IDX_MAX 5'h0F
// bad bit index marker
`define BIT_IDX_BAD 5'h1F
// reset values
`define WORD_RST 16'h0000
`define COUNT_ONE 8'h01
`endif

/* hw/ladder_coil_pkg.sv */
// types of the coil and edge instruction logic
// assumes the map header sits beside it
`include "ladder_coil_map.svh"
package ladder_coil_pkg;
	// instruction codes, handed in by the sequencer each step
	typedef enum logic [4:0] {
		OP_NOP,
		OP_BEGIN,
		OP_RISE_START,
		OP_FALL_START,
		OP_RISE_PAR,
		OP_FALL_PAR,
		OP_RISE_SER,
		OP_FALL_SER,
		OP_SER_MERGE,
		OP_PAR_MERGE,
		OP_INVERT,
		OP_COIL,
		OP_OR_COIL,
		OP_WORD_BIT,
		OP_ONE_SHOT,
		OP_SET,
		OP_RESET,
		OP_RUNG_END
	} op_t;
endpackage : ladder_coil_pkg

/* hw/edge_history.sv */
// per-instruction previous-value store for edge detection
// assumes an asynchronous active-low reset with synchronised release from the parent
`timescale 1ns/1ps
`default_nettype none
`include "ladder_coil_map.svh"
module edge_history (
	input wire logic clk_i,
	input wire logic rst_n_i,
	input wire logic upd_i,
	input wire logic [`SLOT_W-1:0] slot_i,
	input wire logic cur_i,
	output logic rise_o,
	output logic fall_o
);
	logic [`EDGE_SLOTS-1:0] prev_reg;

	// edge terms against the copy from the previous execution
	assign rise_o = cur_i & ~prev_reg[slot_i];
	assign fall_o = ~cur_i & prev_reg[slot_i];

	// copy refreshed at every execution
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			prev_reg <= '0;
		end else if (upd_i) begin
			prev_reg[slot_i] <= cur_i;
		end
	end
endmodule : edge_history
`default_nettype wire

/* hw/ladder_coil_exec.sv */
// coil, edge contact, latch and stack execution for one step per clock
// assumes the sequencer supplies operands read from the image and memory
`timescale 1ns/1ps
`default_nettype none
`include "ladder_coil_map.svh"
module ladder_coil_exec
	import ladder_coil_pkg::*;
(
	input wire logic sys_clk_i,
	input wire logic reset_n_i,
	input wire logic scan_start_i,
	input wire logic instr_valid_i,
	input wire logic [4:0] op_i,
	input wire logic [15:0] addr_i,
	input wire logic point_val_i,
	input wire logic [15:0] word_i,
	input wire logic [7:0] bit_idx_i,
	input wire logic [7:0] count_i,
	input wire logic [`SLOT_W-1:0] slot_i,
	output logic wr_en_o,
	output logic wr_word_o,
	output logic [15:0] wr_addr_o,
	output logic [15:0] wr_data_o,
	output logic [7:0] wr_count_o,
	output logic rung_o,
	output logic [`DEPTH_W-1:0] depth_o,
	output logic stack_err_o,
	output logic index_err_o
);
	// ---------------------------------------------------------------
	// reset release
	// ---------------------------------------------------------------
	logic [1:0] rst_sync_reg;
	logic rst_n;
	always_ff @(posedge sys_clk_i or negedge reset_n_i) begin
		if (!reset_n_i) begin
			rst_sync_reg <= 2'b00;
		end else begin
			rst_sync_reg <= {rst_sync_reg[0], 1'b1};
		end
	end
	assign rst_n = rst_sync_reg[1];

	// ---------------------------------------------------------------
	// helpers
	// ---------------------------------------------------------------
	// BCD bit index to binary, bad marker when not BCD or beyond 15
	function automatic logic [4:0] bcd_bit(input logic [7:0] b);
		logic [4:0] v;
		v = `BIT_IDX_BAD;
		if (b[7:4] == 4'h0 && b[3:0] <= 4'h9) begin
			v = {1'b0, b[3:0]};
		end else if (b[7:4] == 4'h1 && b[3:0] <= 4'h5) begin
			v = {1'b0, b[3:0]} + 5'h0A;
		end
		return v;
	endfunction : bcd_bit

	// ---------------------------------------------------------------
	// state
	// ---------------------------------------------------------------
	logic [`STACK_DEPTH-1:0] stk_reg, stk_next;
	logic [`DEPTH_W-1:0] depth_reg, depth_next;
	logic [`OR_SLOTS-1:0] or_acc_reg, or_seen_reg;
	logic wr_en_reg, wr_word_reg, rung_reg, stack_err_reg, index_err_reg;
	logic [15:0] wr_addr_reg, wr_data_reg;
	logic [7:0] wr_count_reg;
	logic we, wword, ovf, und, bad_idx, upd, ecur, rise, fall;
	logic do_push, push_val, mod_top, top_new, do_merge, merge_or, top;
	logic or_hit, or_write;
	logic [15:0] wdata, word_src;
	logic [7:0] wcnt;
	logic [4:0] bidx;
	op_t op;

	assign op = op_t'(op_i);
	assign top = (depth_reg == '0) ? 1'b0 : stk_reg[3'(depth_reg - 4'h1)];
	assign bidx = bcd_bit(bit_idx_i);
	assign or_hit = or_seen_reg[slot_i[3:0]] & ~scan_start_i;
	// a word written last step is not yet in memory, so forward it
	assign word_src = (wr_en_reg && wr_word_reg && wr_addr_reg == addr_i) ? wr_data_reg : word_i;

	edge_history u_edge (
		.clk_i(sys_clk_i),
		.rst_n_i(rst_n),
		.upd_i(upd),
		.slot_i(slot_i),
		.cur_i(ecur),
		.rise_o(rise),
		.fall_o(fall)
	);

	// ---------------------------------------------------------------
	// instruction decode
	// ---------------------------------------------------------------
	always_comb begin
		we = 1'b0;
		wword = 1'b0;
		wdata = `WORD_RST;
		wcnt = `COUNT_ONE;
		bad_idx = 1'b0;
		upd = 1'b0;
		ecur = point_val_i;
		do_push = 1'b0;
		push_val = 1'b0;
		mod_top = 1'b0;
		top_new = top;
		do_merge = 1'b0;
		merge_or = 1'b0;
		or_write = 1'b0;
		if (instr_valid_i) begin
			case (op)
				OP_BEGIN: begin
					do_push = 1'b1;
					push_val = point_val_i;
				end
				OP_RISE_START: begin
					upd = 1'b1;
					do_push = 1'b1;
					push_val = rise;
				end
				OP_FALL_START: begin
					upd = 1'b1;
					do_push = 1'b1;
					push_val = fall;
				end
				OP_RISE_PAR: begin
					upd = 1'b1;
					mod_top = 1'b1;
					top_new = top | rise;
				end
				OP_FALL_PAR: begin
					upd = 1'b1;
					mod_top = 1'b1;
					top_new = top | fall;
				end
				OP_RISE_SER: begin
					upd = 1'b1;
					mod_top = 1'b1;
					top_new = top & rise;
				end
				OP_FALL_SER: begin
					upd = 1'b1;
					mod_top = 1'b1;
					top_new = top & fall;
				end
				OP_SER_MERGE: do_merge = 1'b1;
				OP_PAR_MERGE: begin
					do_merge = 1'b1;
					merge_or = 1'b1;
				end
				OP_INVERT: begin
					mod_top = 1'b1;
					top_new = ~top;
				end
				OP_COIL: begin
					we = 1'b1;
					wdata = {15'h0000, top};
				end
				OP_OR_COIL: begin
					we = 1'b1;
					or_write = 1'b1;
					wdata = {15'h0000, top | (or_hit & or_acc_reg[slot_i[3:0]])};
				end
				OP_WORD_BIT: begin
					if (bidx > `BIT_IDX_MAX) begin
						bad_idx = 1'b1;
					end else begin
						we = 1'b1;
						wword = 1'b1;
						wdata = word_src;
						wdata[bidx[3:0]] = top;
					end
				end
				OP_ONE_SHOT: begin
					upd = 1'b1;
					ecur = top;
					we = 1'b1;
					wdata = {15'h0000, rise};
				end
				OP_SET: begin
					we = top;
					wdata = 16'h0001;
					wcnt = count_i;
				end
				OP_RESET: begin
					we = top;
					wdata = `WORD_RST;
					wcnt = count_i;
				end
				default: begin
				end
			endcase
		end
	end

	// stack update: push, top rewrite or merge
	always_comb begin
		stk_next = stk_reg;
		depth_next = depth_reg;
		ovf = 1'b0;
		und = 1'b0;
		if (instr_valid_i && op == OP_RUNG_END) begin
			depth_next = '0;
		end else if (do_push) begin
			if (depth_reg == `STACK_DEPTH) begin
				ovf = 1'b1;
			end else begin
				stk_next[3'(depth_reg)] = push_val;
				depth_next = depth_reg + 4'h1;
			end
		end else if (mod_top) begin
			if (depth_reg == '0) begin
				und = 1'b1;
			end else begin
				stk_next[3'(depth_reg - 4'h1)] = top_new;
			end
		end else if (do_merge) begin
			if (depth_reg < 4'h2) begin
				und = 1'b1;
			end else begin
				stk_next[3'(depth_reg - 4'h2)] = merge_or ? (stk_next[3'(depth_reg - 4'h2)] | top)
					: (stk_next[3'(depth_reg - 4'h2)] & top);
				depth_next = depth_reg - 4'h1;
			end
		end
	end

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	// boolean stack, rung visible on its top
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			stk_reg <= '0;
			depth_reg <= '0;
			rung_reg <= 1'b0;
		end else begin
			stk_reg <= stk_next;
			depth_reg <= scan_start_i ? '0 : depth_next;
			rung_reg <= (depth_next == '0) ? 1'b0 : stk_next[3'(depth_next - 4'h1)];
		end
	end

	// or-coil accumulation, write in the start cycle counts as first
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			or_acc_reg <= '0;
			or_seen_reg <= '0;
		end else begin
			if (scan_start_i) begin
				or_seen_reg <= '0;
			end
			if (or_write) begin
				or_seen_reg[slot_i[3:0]] <= 1'b1;
				or_acc_reg[slot_i[3:0]] <= wdata[0];
			end
		end
	end

	// write command toward image and memory
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			wr_en_reg <= 1'b0;
			wr_word_reg <= 1'b0;
			wr_addr_reg <= `WORD_RST;
			wr_data_reg <= `WORD_RST;
			wr_count_reg <= `COUNT_ONE;
		end else begin
			wr_en_reg <= we;
			wr_word_reg <= wword;
			wr_addr_reg <= addr_i;
			wr_data_reg <= wdata;
			wr_count_reg <= wcnt;
		end
	end

	// sticky faults, cleared at scan start unless raised again
	always_ff @(posedge sys_clk_i or negedge rst_n) begin
		if (!rst_n) begin
			stack_err_reg <= 1'b0;
			index_err_reg <= 1'b0;
		end else begin
			stack_err_reg <= ovf | und | (stack_err_reg & ~scan_start_i);
			index_err_reg <= bad_idx | (index_err_reg & ~scan_start_i);
		end
	end

	assign wr_en_o = wr_en_reg;
	assign wr_word_o = wr_word_reg;
	assign wr_addr_o = wr_addr_reg;
	assign wr_data_o = wr_data_reg;
	assign wr_count_o = wr_count_reg;
	assign rung_o = rung_reg;
	assign depth_o = depth_reg;
	assign stack_err_o = stack_err_reg;
	assign index_err_o = index_err_reg;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	default clocking cb @(posedge sys_clk_i);
	endclocking
	default disable iff (!rst_n);

	logic ex;
	assign ex = instr_valid_i && !scan_start_i;
	a_coil_copy: assert property (ex && op == OP_COIL |=> wr_en_o && wr_data_o[0] == $past(top))
		else $error("coil did not copy rung");
	a_or_coil_hold: assert property (ex && op == OP_OR_COIL && or_hit && or_acc_reg[slot_i[3:0]]
		|=> wr_en_o && wr_data_o[0])
		else $error("or coil lost earlier rung");
	a_word_bit_set: assert property (ex && op == OP_WORD_BIT && bidx <= `BIT_IDX_MAX
		|=> wr_word_o && wr_data_o[$past(bidx[3:0])] == $past(top))
		else $error("word bit not written");
	a_word_forward: assert property (ex && op == OP_WORD_BIT && bidx <= `BIT_IDX_MAX ##1
		ex && op == OP_WORD_BIT && bidx <= `BIT_IDX_MAX && addr_i == $past(addr_i)
		|=> ((wr_data_o ^ $past(wr_data_o)) & ~(16'h0001 << $past(bidx[3:0]))) == 16'h0000)
		else $error("word bit forwarding lost");
	a_invert_top: assert property (ex && op == OP_INVERT && depth_reg != '0 |=> rung_o == !$past(top))
		else $error("invert failed");
	a_one_shot_pulse: assert property (ex && op == OP_ONE_SHOT && top ##1 ex && op == OP_ONE_SHOT
		&& slot_i == $past(slot_i) |=> !wr_data_o[0])
		else $error("one shot longer than one step");
	a_rise_start_push: assert property (ex && op == OP_RISE_START && depth_reg < `STACK_DEPTH
		|=> depth_o == $past(depth_reg) + 4'h1 && rung_o == $past(rise))
		else $error("rising start push wrong");
	a_set_range: assert property (ex && op == OP_SET && top |=> wr_en_o && wr_data_o == 16'h0001
		&& wr_count_o == $past(count_i))
		else $error("set not issued");
	a_reset_range: assert property (ex && op == OP_RESET && top |=> wr_en_o && wr_data_o == 16'h0000)
		else $error("reset not issued");
	a_depth_limit: assert property (depth_o <= `STACK_DEPTH)
		else $error("stack deeper than eight");

	c_one_shot: cover property (ex && op == OP_ONE_SHOT && rise);
	c_overflow: cover property (ovf);
	c_par_merge: cover property (ex && op == OP_PAR_MERGE && depth_reg == 4'h2);
	c_word_back: cover property (ex && op == OP_WORD_BIT ##1 ex && op == OP_WORD_BIT);
endmodule : ladder_coil_exec
`default_nettype wire

/* tb/tb_ladder_coil_exec.sv */
// self-checking bench for the coil, edge contact, latch and stack step logic
// assumes the package and map header from hw/ are compiled first
`timescale 1ns/1ps
`default_nettype none
`include "ladder_coil_map.svh"
module tb_ladder_coil_exec
	import ladder_coil_pkg::*;
;
	logic sys_clk_i = 1'b0;
	logic reset_n_i = 1'b0;
	logic scan_start_i = 1'b0;
	logic instr_valid_i = 1'b0;
	logic [4:0] op_i = 5'h00;
	logic [15:0] addr_i = 16'h0000;
	logic point_val_i = 1'b0;
	logic [15:0] word_i = 16'h0000;
	logic [7:0] bit_idx_i = 8'h00;
	logic [7:0] count_i = 8'h01;
	logic [`SLOT_W-1:0] slot_i = 5'h00;
	logic wr_en_o, wr_word_o, rung_o, stack_err_o, index_err_o;
	logic [15:0] wr_addr_o, wr_data_o;
	logic [7:0] wr_count_o;
	logic [`DEPTH_W-1:0] depth_o;
	int mismatches = 0;
	int compares = 0;
	int cycles = 0;
	int seed = 32'hdba6_a788;
	logic [31:0] prev = 32'h0000_0000;
	logic r, pv, e, orv;
	logic [15:0] w, a;
	logic [7:0] cnt;

	ladder_coil_exec dut (
		.sys_clk_i(sys_clk_i), .reset_n_i(reset_n_i), .scan_start_i(scan_start_i),
		.instr_valid_i(instr_valid_i), .op_i(op_i), .addr_i(addr_i), .point_val_i(point_val_i),
		.word_i(word_i), .bit_idx_i(bit_idx_i), .count_i(count_i), .slot_i(slot_i),
		.wr_en_o(wr_en_o), .wr_word_o(wr_word_o), .wr_addr_o(wr_addr_o), .wr_data_o(wr_data_o),
		.wr_count_o(wr_count_o), .rung_o(rung_o), .depth_o(depth_o),
		.stack_err_o(stack_err_o), .index_err_o(index_err_o)
	);

	// ----------------------------------------
	// clock and hang guard
	// ----------------------------------------
	initial begin
		forever #2 sys_clk_i = ~sys_clk_i;
	end
	initial begin
		forever begin
			@(posedge sys_clk_i);
			cycles++;
			if (cycles == 20000) begin
				mismatches++;
				print_verdict();
			end
		end
	end

	// ----------------------------------------
	// helpers
	// ----------------------------------------
	task automatic check(input string name, input logic [15:0] seen, input logic [15:0] exp);
		compares++;
		if (seen !== exp) begin
			mismatches++;
			$display("mismatch %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// one instruction taken at the rising edge, outputs looked at on the next falling edge
	task automatic step(input op_t op, input logic [15:0] ad, input logic p, input logic [7:0] bi,
		input logic [7:0] c, input logic [4:0] sl);
		instr_valid_i = 1'b1;
		scan_start_i = 1'b0;
		op_i = op;
		addr_i = ad;
		point_val_i = p;
		bit_idx_i = bi;
		count_i = c;
		slot_i = sl;
		@(posedge sys_clk_i);
		@(negedge sys_clk_i);
	endtask : step

	task automatic scan();
		instr_valid_i = 1'b1;
		scan_start_i = 1'b1;
		op_i = OP_NOP;
		@(posedge sys_clk_i);
		@(negedge sys_clk_i);
	endtask : scan

	function automatic logic [7:0] bcd(input int i);
		return {4'(i / 10), 4'(i % 10)};
	endfunction : bcd

	// edge term of an edge instruction given the point and its history bit
	function automatic logic edge_term(input op_t op, input logic p, input logic h);
		if (op == OP_RISE_START || op == OP_RISE_PAR || op == OP_RISE_SER) begin
			return p & ~h;
		end
		return ~p & h;
	endfunction : edge_term

	task automatic print_verdict();
		$display("compares %0d mismatches %0d", compares, mismatches);
		if (mismatches == 0 && compares > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : print_verdict

	// ----------------------------------------
	// main sequence
	// ----------------------------------------
	initial begin
		repeat (2) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		check("count_rst", {8'h00, wr_count_o}, 16'h0001);
		check("en_rst", {15'h0000, wr_en_o}, 16'h0000);
		reset_n_i = 1'b1;
		repeat (4) @(posedge sys_clk_i);
		@(negedge sys_clk_i);
		// plain coil with and without inversion, twice to the same point
		for (int i = 0; i < 8; i++) begin
			pv = 1'($random(seed));
			a = 16'($random(seed));
			step(OP_BEGIN, a, pv, 8'h00, 8'h01, 5'h1f);
			if (i[0]) begin
				step(OP_INVERT, a, 1'b0, 8'h00, 8'h01, 5'h1f);
				check("rung_inv", {15'h0000, rung_o}, {15'h0000, ~pv});
				pv = ~pv;
			end
			step(OP_COIL, a, 1'b0, 8'h00, 8'h01, 5'h1f);
			check("coil_en", {15'h0000, wr_en_o}, 16'h0001);
			check("coil_data", wr_data_o, {15'h0000, pv});
			check("coil_addr", wr_addr_o, a);
			check("coil_word", {15'h0000, wr_word_o}, 16'h0000);
			// second coil on the same point after inversion carries the later value
			step(OP_INVERT, a, 1'b0, 8'h00, 8'h01, 5'h1f);
			step(OP_COIL, a, 1'b0, 8'h00, 8'h01, 5'h1f);
			check("coil_last", wr_data_o, {15'h0000, ~pv});
			check("coil_last_addr", wr_addr_o, a);
			step(OP_RUNG_END, a, 1'b0, 8'h00, 8'h01, 5'h1f);
			check("end_depth", {12'h000, depth_o}, 16'h0000);
		end
		// or-combined coil over three rungs of one scan
		for (int i = 0; i < 6; i++) begin
			scan();
			orv = 1'b0;
			for (int k = 0; k < 3; k++) begin
				r = 1'($random(seed));
				orv = orv | r;
				step(OP_BEGIN, 16'h0040, r, 8'h00, 8'h01, 5'h1f);
				step(OP_OR_COIL, 16'h0040, 1'b0, 8'h00, 8'h01, 5'h03);
				check("or_coil", wr_data_o, {15'h0000, orv});
				step(OP_RUNG_END, 16'h0040, 1'b0, 8'h00, 8'h01, 5'h1f);
			end
		end
		// word bit coil over every BCD index, then an invalid index
		for (int i = 0; i < 16; i++) begin
			w = 16'($random(seed));
			pv = 1'($random(seed));
			word_i = w;
			step(OP_BEGIN, 16'h0100, pv, 8'h00, 8'h01, 5'h1f);
			step(OP_WORD_BIT, 16'h0100, 1'b0, bcd(i), 8'h01, 5'h1f);
			w[i] = pv;
			check("wbit_data", wr_data_o, w);
			check("wbit_word", {15'h0000, wr_word_o}, 16'h0001);
			step(OP_RUNG_END, 16'h0100, 1'b0, 8'h00, 8'h01, 5'h1f);
		end
		step(OP_BEGIN, 16'h0100, 1'b1, 8'h00, 8'h01, 5'h1f);
		step(OP_WORD_BIT, 16'h0100, 1'b0, 8'h1a, 8'h01, 5'h1f);
		check("wbit_bad_en", {15'h0000, wr_en_o}, 16'h0000);
		check("wbit_bad_err", {15'h0000, index_err_o}, 16'h0001);
		// back-to-back word bit coils on one word with a stale memory word, then the same bit later
		word_i = 16'h0000;
		step(OP_WORD_BIT, 16'h0200, 1'b0, 8'h03, 8'h01, 5'h1f);
		check("wbit_first", wr_data_o, 16'h0008);
		step(OP_WORD_BIT, 16'h0200, 1'b0, 8'h05, 8'h01, 5'h1f);
		check("wbit_fwd", wr_data_o, 16'h0028);
		word_i = 16'h0028;
		step(OP_INVERT, 16'h0200, 1'b0, 8'h00, 8'h01, 5'h1f);
		step(OP_WORD_BIT, 16'h0200, 1'b0, 8'h03, 8'h01, 5'h1f);
		check("wbit_last", wr_data_o, 16'h0020);
		step(OP_RUNG_END, 16'h0200, 1'b0, 8'h00, 8'h01, 5'h1f);
		// edge contacts and one-shot coil on random point sequences
		for (int i = 0; i < 24; i++) begin
			scan();
			for (int k = 2; k <= 7; k++) begin
				pv = 1'($random(seed));
				r = 1'($random(seed));
				e = edge_term(op_t'(k), pv, prev[k]);
				if (k > 3) begin
					step(OP_BEGIN, 16'h0000, r, 8'h00, 8'h01, 5'h1f);
				end
				step(op_t'(k), 16'h0000, pv, 8'h00, 8'h01, 5'(k));
				prev[k] = pv;
				case (k)
					2: check("edge_rise_start", {15'h0000, rung_o}, {15'h0000, e});
					3: check("edge_fall_start", {15'h0000, rung_o}, {15'h0000, e});
					4: check("edge_rise_par", {15'h0000, rung_o}, {15'h0000, r | e});
					5: check("edge_fall_par", {15'h0000, rung_o}, {15'h0000, r | e});
					6: check("edge_rise_ser", {15'h0000, rung_o}, {15'h0000, r & e});
					default: check("edge_fall_ser", {15'h0000, rung_o}, {15'h0000, r & e});
				endcase
				step(OP_RUNG_END, 16'h0000, 1'b0, 8'h00, 8'h01, 5'h1f);
			end
			r = 1'($random(seed));
			step(OP_BEGIN, 16'h0300, r, 8'h00, 8'h01, 5'h1f);
			step(OP_ONE_SHOT, 16'h0300, 1'b0, 8'h00, 8'h01, 5'h08);
			check("one_shot", wr_data_o, {15'h0000, r & ~prev[8]});
			prev[8] = r;
			// same one-shot again at once: no second pulse
			step(OP_ONE_SHOT, 16'h0300, 1'b0, 8'h00, 8'h01, 5'h08);
			check("one_shot_again", wr_data_o, 16'h0000);
			step(OP_RUNG_END, 16'h0300, 1'b0, 8'h00, 8'h01, 5'h1f);
		end
		// latch set and reset over ranges, only with the rung on
		for (int i = 0; i < 8; i++) begin
			r = 1'($random(seed));
			cnt = 8'(($random(seed) & 15) + 1);
			step(OP_BEGIN, 16'h0400, r, 8'h00, 8'h01, 5'h1f);
			step(i[0] ? OP_RESET : OP_SET, 16'h0400, 1'b0, 8'h00, cnt, 5'h1f);
			check("latch_en", {15'h0000, wr_en_o}, {15'h0000, r});
			if (r) begin
				check("latch_data", wr_data_o, {15'h0000, ~i[0]});
				check("latch_cnt", {8'h00, wr_count_o}, {8'h00, cnt});
			end
			step(OP_RUNG_END, 16'h0400, 1'b0, 8'h00, 8'h01, 5'h1f);
		end
		// stack merges, overflow at eight levels and underflow
		scan();
		step(OP_BEGIN, 16'h0000, 1'b1, 8'h00, 8'h01, 5'h1f);
		step(OP_BEGIN, 16'h0000, 1'b0, 8'h00, 8'h01, 5'h1f);
		step(OP_SER_MERGE, 16'h0000, 1'b0, 8'h00, 8'h01, 5'h1f);
		check("ser_merge", {11'h000, depth_o, rung_o}, 16'h0002);
		step(OP_BEGIN, 16'h0000, 1'b1, 8'h00, 8'h01, 5'h1f);
		step(OP_PAR_MERGE, 16'h0000, 1'b0, 8'h00, 8'h01, 5'h1f);
		check("par_merge", {11'h000, depth_o, rung_o}, 16'h0003);
		for (int i = 0; i < 8; i++) begin
			step(OP_BEGIN, 16'h0000, 1'b1, 8'h00, 8'h01, 5'h1f);
		end
		check("stack_full", {11'h000, depth_o, stack_err_o}, 16'h0011);
		scan();
		check("err_clear", {15'h0000, stack_err_o}, 16'h0000);
		step(OP_SER_MERGE, 16'h0000, 1'b0, 8'h00, 8'h01, 5'h1f);
		check("underflow", {15'h0000, stack_err_o}, 16'h0001);
		instr_valid_i = 1'b0;
		print_verdict();
	end
endmodule : tb_ladder_coil_exec
`default_nettype wire
